//--- gpc_defs.vh
/*
 Constants for the receiver power-state sequencer: clock period,
 timing figures in their printed units and derived cycle counts.
 Assumes a 10 MHz reference clock (100 ns period).
*/
`ifndef GPC_DEFS_VH
`define GPC_DEFS_VH

// ----------------------------------------
// Clock
// ----------------------------------------
`define GPC_CLK_PERIOD_NS 100

// ----------------------------------------
// Timing figures, printed units
// ----------------------------------------
`define GPC_SHUTDOWN_MAX_MS 1000
`define GPC_PPS_MIN_NS 620
`define GPC_PPS_MAX_NS 710
`define GPC_TIME_MSG_MS 300
`define GPC_PTF_SLEEP_S 7200
`define GPC_SECOND_NS 1000000000
`define GPC_HIB_DELAY_MS 10

// ----------------------------------------
// Derived cycle counts
// ----------------------------------------
`define GPC_SECOND_CYC (`GPC_SECOND_NS / `GPC_CLK_PERIOD_NS)
// Least time, rounded up
`define GPC_PPS_DLY_CYC ((`GPC_PPS_MIN_NS + `GPC_CLK_PERIOD_NS - 1) / `GPC_CLK_PERIOD_NS)
// Longest time, rounded down, less one cycle
`define GPC_SHUT_CYC ((`GPC_SHUTDOWN_MAX_MS * 1000000 / `GPC_CLK_PERIOD_NS) - 1)
`define GPC_MSG_DLY_CYC (`GPC_TIME_MSG_MS * 1000000 / `GPC_CLK_PERIOD_NS)
`define GPC_HIB_DLY_CYC (`GPC_HIB_DELAY_MS * 1000000 / `GPC_CLK_PERIOD_NS)
// Push-to-fix sleep in seconds
`define GPC_PTF_SEC `GPC_PTF_SLEEP_S

// ----------------------------------------
// Update rate divisors (second ticks split)
// ----------------------------------------
`define GPC_RATE_1HZ 1
`define GPC_RATE_5HZ 5

`endif

//--- gpc_power_ctrl.v
/*
 Power-state sequencer of a satellite navigation receiver module, with the
 once-per-second pulse, time message strobe and navigation update strobe.
 Assumes all inputs synchronous to ref_clk; the message parser outside
 decodes serial commands into one-cycle command pulses.
*/
// Operation
// - Messages flow right after successful start
// - Toggle low or command begins shutdown
// - Shutdown completes within one second
// - Push-to-fix sleeps, wakes periodically to refresh (here it wakes once at the PTF_SEC-th second tick after entry and stays in run)
// - Hibernate after short delay on shutdown
// - Hibernate keeps clock and memory alive
// - Second pulse 620-710ns after second
// - Time messages about 300ms after pulse
// - Update rate 1Hz, 5Hz by command
`timescale 1ns/1ps
`include "gpc_defs.vh"

module gpc_power_ctrl #(
   parameter SECOND_CYC = `GPC_SECOND_CYC,
   parameter SHUT_CYC = `GPC_SHUT_CYC,
   parameter MSG_DLY_CYC = `GPC_MSG_DLY_CYC,
   parameter HIB_DLY_CYC = `GPC_HIB_DLY_CYC,
   parameter PTF_SEC = `GPC_PTF_SEC,
   parameter PPS_DLY_CYC = `GPC_PPS_DLY_CYC,
   parameter PULSE_CYC = 1000000
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Host toggle pin
   input wire power_toggle_in,
   // Decoded serial commands, one-cycle pulses
   input wire cmd_shutdown,
   input wire cmd_low_power,
   input wire cmd_push_to_fix,
   input wire cmd_rate_5hz_on,
   input wire cmd_rate_5hz_off,
   // Pins and status
   output reg wake_indicator_out,
   output reg second_pulse_out,
   output reg time_msg_strobe,
   output reg nav_update_strobe,
   output reg msg_enable,
   output reg rtc_run,
   output reg sram_retain,
   output reg [5:0] power_state
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam ST_OFF = 6'b00_0001;
   localparam ST_RUN = 6'b00_0010;
   localparam ST_SHUT = 6'b00_0100;
   localparam ST_HIB = 6'b00_1000;
   localparam ST_AWARE = 6'b01_0000;
   localparam ST_PTF = 6'b10_0000;

   reg [5:0] state_q;
   reg [5:0] state_d;
   reg tog_q;
   reg [31:0] tmr_q;
   reg [31:0] tmr_d;
   reg [31:0] sec_cnt_q;
   reg [31:0] ptf_sec_q;
   reg [31:0] pps_cnt_q;
   reg [31:0] msg_cnt_q;
   reg rate5_q;
   reg [2:0] sub_q;

   wire rise = power_toggle_in & ~tog_q;
   wire fall = ~power_toggle_in & tog_q;
   wire running = state_q == ST_RUN;
   wire sec_tick = running && (sec_cnt_q == SECOND_CYC - 1);
   wire ptf_due = (state_q == ST_PTF) && (ptf_sec_q >= PTF_SEC - 1) && (sec_cnt_q == SECOND_CYC - 1);
   // Fifth of a second for the fast update rate
   wire fifth_tick = running && (sec_cnt_q % (SECOND_CYC / 5) == (SECOND_CYC / 5) - 1);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always @* begin
      state_d = state_q;
      tmr_d = tmr_q;
      case (state_q)
         ST_OFF, ST_HIB: begin
            if (rise) begin
               state_d = ST_RUN;
               tmr_d = 32'h0000_0000;
            end
         end
         ST_RUN: begin
            if (fall || cmd_shutdown) begin
               state_d = ST_SHUT;
               tmr_d = 32'h0000_0000;
            end else if (cmd_low_power) begin
               state_d = ST_AWARE;
            end else if (cmd_push_to_fix) begin
               state_d = ST_PTF;
            end
         end
         ST_SHUT: begin
            // Short delay then hibernate, never later than the limit
            if (tmr_q >= HIB_DLY_CYC - 1 || tmr_q >= SHUT_CYC - 1) begin
               state_d = ST_HIB;
            end else begin
               tmr_d = tmr_q + 32'h0000_0001;
            end
         end
         ST_AWARE: begin
            if (rise) begin
               state_d = ST_RUN;
            end
         end
         ST_PTF: begin
            if (rise || ptf_due) begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_OFF;
      endcase
   end

   // ----------------------------------------
   // State, second base and push-to-fix timer
   // ----------------------------------------
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_OFF;
         tmr_q <= 32'h0000_0000;
         tog_q <= 1'b0;
         sec_cnt_q <= 32'h0000_0000;
         ptf_sec_q <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
         tog_q <= power_toggle_in;
         // Second base keeps running in the aware and push-to-fix modes so the refresh stays periodic; off and hibernate clear it
         if (sec_cnt_q == SECOND_CYC - 1) begin
            sec_cnt_q <= 32'h0000_0000;
         end else if (state_q == ST_OFF || state_q == ST_HIB) begin
            sec_cnt_q <= 32'h0000_0000;
         end else begin
            sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
         end
         if (state_q != ST_PTF) begin
            ptf_sec_q <= 32'h0000_0000;
         end else if (sec_cnt_q == SECOND_CYC - 1) begin
            ptf_sec_q <= ptf_sec_q + 32'h0000_0001;
         end
      end
   end

   // ----------------------------------------
   // Second pulse and time message strobe
   // ----------------------------------------
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pps_cnt_q <= 32'h0000_0000;
         msg_cnt_q <= 32'h0000_0000;
         second_pulse_out <= 1'b0;
         time_msg_strobe <= 1'b0;
      end else begin
         time_msg_strobe <= 1'b0;
         // Delay after the second edge, then hold high for a fixed width
         if (sec_tick) begin
            pps_cnt_q <= 32'h0000_0001;
         end else if (pps_cnt_q != 32'h0000_0000) begin
            pps_cnt_q <= (pps_cnt_q >= PPS_DLY_CYC + PULSE_CYC) ? 32'h0000_0000 : pps_cnt_q + 32'h0000_0001;
         end
         // A started pulse runs its full width even past a mode change, so no runt pulse reaches the pin
         second_pulse_out <= pps_cnt_q >= PPS_DLY_CYC;
         // Time message follows the pulse rise
         if (pps_cnt_q == PPS_DLY_CYC) begin
            msg_cnt_q <= 32'h0000_0001;
         end else if (msg_cnt_q != 32'h0000_0000) begin
            if (msg_cnt_q == MSG_DLY_CYC) begin
               msg_cnt_q <= 32'h0000_0000;
               time_msg_strobe <= running;
            end else begin
               msg_cnt_q <= msg_cnt_q + 32'h0000_0001;
            end
         end
      end
   end

   // ----------------------------------------
   // Update rate and status outputs
   // ----------------------------------------
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rate5_q <= 1'b0;
         sub_q <= 3'b000;
         nav_update_strobe <= 1'b0;
         wake_indicator_out <= 1'b0;
         msg_enable <= 1'b0;
         rtc_run <= 1'b0;
         sram_retain <= 1'b0;
         power_state <= ST_OFF;
      end else begin
         if (cmd_rate_5hz_on) begin
            rate5_q <= 1'b1;
         end else if (cmd_rate_5hz_off) begin
            rate5_q <= 1'b0;
         end
         nav_update_strobe <= rate5_q ? fifth_tick : sec_tick;
         wake_indicator_out <= state_d == ST_RUN;
         msg_enable <= state_d == ST_RUN;
         // Clock and backed memory stay alive in every powered state
         rtc_run <= state_d != ST_OFF;
         sram_retain <= state_d != ST_OFF;
         power_state <= state_d;
      end
   end

endmodule // gpc_power_ctrl

//--- gpc_props.sv
/* Port checker for the power sequencer.
   Assumes it is bound to gpc_power_ctrl. */
`timescale 1ns/1ps
module gpc_props #(
   parameter int MSG_DLY_CYC = 30
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Watched ports
   input wire power_toggle_in,
   input wire cmd_shutdown,
   input wire cmd_low_power,
   input wire cmd_push_to_fix,
   input wire wake_indicator_out,
   input wire second_pulse_out,
   input wire time_msg_strobe,
   input wire msg_enable,
   input wire rtc_run,
   input wire sram_retain,
   input wire [5:0] power_state
);
   // Slack of one cycle either side of the message delay
   localparam int MLO = MSG_DLY_CYC - 1;
   localparam int MHI = MSG_DLY_CYC + 1;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   property p_wake; (power_state & 6'h39) != 6'h00 && $rose(power_toggle_in) |=> power_state == 6'h02; endproperty
   a_wake: assert property (p_wake) else $error("toggle rise did not start");
   property p_run; power_state == 6'h02 |-> wake_indicator_out && msg_enable; endproperty
   a_run: assert property (p_run) else $error("running without messages");
   property p_pin; power_state == 6'h02 && $fell(power_toggle_in) |=> power_state == 6'h04; endproperty
   a_pin: assert property (p_pin) else $error("toggle low did not shut down");
   property p_cmd; power_state == 6'h02 && cmd_shutdown |=> power_state == 6'h04; endproperty
   a_cmd: assert property (p_cmd) else $error("command did not shut down");
   property p_hib; $rose(power_state == 6'h04) |-> ##[1:99] power_state == 6'h08; endproperty
   a_hib: assert property (p_hib) else $error("shutdown too long");
   property p_keep; power_state != 6'h01 |-> rtc_run && sram_retain; endproperty
   a_keep: assert property (p_keep) else $error("clock or memory dropped");
   property p_pps; $rose(second_pulse_out) |-> second_pulse_out [*8]; endproperty
   a_pps: assert property (p_pps) else $error("second pulse too short");
   property p_msg; $rose(second_pulse_out) && msg_enable |-> ##[MLO:MHI] (time_msg_strobe || !msg_enable); endproperty
   a_msg: assert property (p_msg) else $error("time message late");
   property p_ptf; power_state == 6'h02 && cmd_push_to_fix && !cmd_shutdown && !cmd_low_power &&
      !$fell(power_toggle_in) |=> power_state == 6'h20;
   endproperty
   a_ptf: assert property (p_ptf) else $error("push to fix not entered");
endmodule // gpc_props
bind gpc_power_ctrl gpc_props #(.MSG_DLY_CYC(MSG_DLY_CYC)) u_props (.*);

//--- gpc_host_model.sv
/* Host model driving the toggle pin.
   Assumes the bench asks for on or off by a level. */
`timescale 1ns/1ps
module gpc_host_model #(
   parameter int WAIT_CYC = 20
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Bench request and pins
   input wire want_on,
   input wire wake_in,
   output logic toggle_out
);
   logic [7:0] up_q;
   logic [7:0] idle_q;
   logic wake_prev_q;
   logic seen_q;
   // Toggle only once wake rises or the power-up wait runs out
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         up_q <= 8'h00;
         idle_q <= 8'h00;
         wake_prev_q <= 1'b0;
         seen_q <= 1'b0;
         toggle_out <= 1'b0;
      end else begin
         wake_prev_q <= wake_in;
         if (wake_in && !wake_prev_q) up_q <= 8'(WAIT_CYC);
         else if (up_q < 8'(WAIT_CYC)) up_q <= up_q + 8'h01;
         // Retry only when this pulse never got an answer; sleep modes drop wake on purpose
         seen_q <= toggle_out && (seen_q || wake_in);
         idle_q <= (toggle_out && !seen_q && !wake_in) ? idle_q + 8'h01 : 8'h00;
         // No sign of life: drop, so the next cycle is a fresh pulse
         if (idle_q == 8'h3c) toggle_out <= 1'b0;
         else toggle_out <= want_on && up_q >= 8'(WAIT_CYC);
      end
   end
endmodule // gpc_host_model

//--- gpc_power_ctrl_tb.sv
/* Self-checking bench for the power sequencer.
   Assumes shortened second and delay parameters. */
`timescale 1ns/1ps
module gpc_power_ctrl_tb;
   logic ref_clk = 0, reset_n = 0, want_on = 0;
   logic [4:0] cmd = 5'h00;
   logic [31:0] rnd = 32'h0000_f33f;
   logic [5:0] prev = 6'h01;
   logic [5:0] exp_q[$];
   logic [4:0] codes[5] = '{5'h02, 5'h04, 5'h07, 5'h06, 5'h01};
   logic [5:0] nexts[5] = '{6'h10, 6'h20, 6'h04, 6'h10, 6'h04};
   wire toggle, wake, pps, tmsg, nav, men, rtc, sram;
   wire [5:0] st;
   int err_total = 0, checks_done = 0, n, np, nm;
   logic pps_prev;
   initial forever #50 ref_clk = ~ref_clk;
   gpc_host_model #(.WAIT_CYC(20)) u_host (.ref_clk(ref_clk), .reset_n(reset_n), .want_on(want_on),
      .wake_in(wake), .toggle_out(toggle));
   gpc_power_ctrl #(.SECOND_CYC(100), .SHUT_CYC(99), .MSG_DLY_CYC(30), .HIB_DLY_CYC(10), .PTF_SEC(3),
      .PULSE_CYC(10)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .power_toggle_in(toggle),
      .cmd_shutdown(cmd[0]), .cmd_low_power(cmd[1]), .cmd_push_to_fix(cmd[2]), .cmd_rate_5hz_on(cmd[3]),
      .cmd_rate_5hz_off(cmd[4]), .wake_indicator_out(wake), .second_pulse_out(pps), .time_msg_strobe(tmsg),
      .nav_update_strobe(nav), .msg_enable(men), .rtc_run(rtc), .sram_retain(sram), .power_state(st));
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input string nm, input logic [5:0] e, input logic [5:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Bounded wait until every noted state has been seen
   task settle;
      n = 0;
      while (exp_q.size() > 0 && n < 400) begin
         @(negedge ref_clk);
         n++;
      end
      chk("pending", 6'h00, 6'(exp_q.size()));
   endtask
   task pulse(input logic [4:0] c);
      @(negedge ref_clk);
      cmd = c;
      @(negedge ref_clk);
      cmd = 5'h00;
      repeat (5) @(negedge ref_clk);
   endtask
   // One second window: update strobes, pulse rises and time messages
   task cnt_nav(input logic [5:0] e);
      n = 0;
      np = 0;
      nm = 0;
      pps_prev = pps;
      repeat (100) begin
         @(negedge ref_clk);
         n += int'(nav === 1'b1);
         np += int'(pps === 1'b1 && pps_prev === 1'b0);
         nm += int'(tmsg === 1'b1);
         pps_prev = pps;
      end
      chk("nav count", e, 6'(n));
      chk("pulse count", 6'h01, 6'(np));
      chk("message count", 6'h01, 6'(nm));
   endtask
   // Monitor: each state change takes the oldest note
   always @(negedge ref_clk) begin
      if (reset_n && st !== prev) begin
         prev = st;
         chk("state", exp_q.size() > 0 ? exp_q.pop_front() : 6'h3f, st);
         chk("status", {2'b00, st == 6'h02, st == 6'h02, st != 6'h01, st != 6'h01}, {2'b00, wake, men, rtc, sram});
      end
   end
   initial begin
      repeat (8) @(negedge ref_clk);
      reset_n = 1;
      exp_q.push_back(6'h02);
      want_on = 1;
      settle();
      // Wait half of the first second so every window sees whole periods
      repeat (50) @(negedge ref_clk);
      pulse(5'h08);
      cnt_nav(6'h05);
      pulse(5'h10);
      cnt_nav(6'h01);
      exp_q.push_back(6'h04);
      exp_q.push_back(6'h08);
      want_on = 0;
      settle();
      exp_q.push_back(6'h02);
      want_on = 1;
      settle();
      // Commands alone and together, random spacing
      for (int i = 0; i < 5; i++) begin
         rnd = lfsr(rnd);
         repeat (int'(rnd[4:0]) + 2) @(negedge ref_clk);
         exp_q.push_back(nexts[i]);
         if (nexts[i] == 6'h04) exp_q.push_back(6'h08);
         // Random rate commands ride along; they must not disturb the state
         pulse(codes[i] | {rnd[6:5], 3'b000});
         settle();
         want_on = 0;
         repeat (3) @(negedge ref_clk);
         exp_q.push_back(6'h02);
         want_on = 1;
         settle();
      end
      // Push-to-fix left alone must wake by itself within its sleep span
      exp_q.push_back(6'h20);
      exp_q.push_back(6'h02);
      pulse(5'h04);
      settle();
      give_verdict();
   end
   initial begin
      #(100 * 6000);
      err_total++;
      give_verdict();
   end
endmodule // gpc_power_ctrl_tb
